/* core/rtts_pkg.sv */
// Purpose: shared constants and types for the radio transmit task sequencer
// Assumes: 50 MHz system clock, classic wishbone register access
// Notes:   register offsets are byte addresses of aligned 32-bit words
package rtts_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CHAN    = 8'h04;
    localparam logic [7:0] ADDR_CONF    = 8'h08;
    localparam logic [7:0] ADDR_TIME    = 8'h0c;
    localparam logic [7:0] ADDR_ENTRY   = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_CNT_TX  = 8'h18;
    localparam logic [7:0] ADDR_CNT_RX  = 8'h1c;
    localparam logic [7:0] ADDR_EVENTS  = 8'h20;

    // control bit positions
    localparam int CTRL_START = 0;

    // conf field positions
    localparam int CF_MODE     = 0;   // 2 bits task_mode
    localparam int CF_ADSRC    = 2;   // 2 bits tx_address_source
    localparam int CF_ADDRCFG  = 4;   // address configured
    localparam int CF_CRCLEN   = 5;   // 2 bits crc_byte_count
    localparam int CF_AA       = 7;   // auto_acknowledge_flag
    localparam int CF_FIXLEN   = 8;   // fixed_length_flag
    localparam int CF_FIXSEQ   = 9;   // fixed_sequence_flag
    localparam int CF_REUSE    = 10;
    localparam int CF_VARIABLE_LENGTH_FLAG   = 11;  // variable_length_flag
    localparam int CF_ADLEN    = 12;  // address_length_setting
    localparam int CF_AFLUSH   = 13;  // crc_autoflush
    localparam int CF_HDR10    = 14;  // 10-bit header
    localparam int CF_CFGBYTE  = 15;  // config byte present
    localparam int CF_RTLIM    = 16;  // 4 bits retransmit_limit
    localparam int CF_RXLIM    = 24;  // 6 bits receive_length_limit

    // address sources
    localparam logic [1:0] ASRC_ENTRY0 = 2'h0;
    localparam logic [1:0] ASRC_FIFO   = 2'h1;
    localparam logic [1:0] ASRC_INDEX  = 2'h2;

    // task modes
    localparam logic [1:0] MODE_BASIC_NOLEN = 2'h0;
    localparam logic [1:0] MODE_BASIC_LEN   = 2'h1;

    // fixed-length header values
    localparam logic [6:0] FIXLEN_9BIT  = 7'h33;  // 110011
    localparam logic [6:0] FIXLEN_10BIT = 7'h33;  // 0110011
    localparam logic [5:0] RXLEN_MAX    = 6'h20;  // 32

    // timing: retransmit delay in 62.5 ns units, converted at 20 ns
    localparam int UNIT_PS      = 62500;
    localparam int CLK_PS       = 20000;

    // end causes
    localparam logic [2:0] CAUSE_NONE  = 3'h0;
    localparam logic [2:0] CAUSE_OK    = 3'h1;
    localparam logic [2:0] CAUSE_TXF   = 3'h2;   // tx_fifo_error_cause
    localparam logic [2:0] CAUSE_MAXRT = 3'h3;   // max_retransmit_cause
    localparam logic [2:0] CAUSE_RXF   = 3'h4;

    // event bit positions
    localparam int EV_TRANSMIT_DONE_IRQ = 0;
    localparam int EV_RECEIVE_OK_IRQ   = 1;
    localparam int EV_RXEMP  = 2;
    localparam int EV_RXBAD  = 3;
    localparam int EV_RXFULL = 4;
    localparam int EV_ERR    = 5;
    localparam int EV_ABORT  = 6;
    localparam int EV_DONE   = 7;

    // fifo commands bundle: dealloc, retry, discard
    typedef struct packed {
        logic dealloc;
        logic retry;
        logic discard;
    } rtts_fifo_cmd_t;

    // acknowledgment result from the receiver
    typedef struct packed {
        logic       valid;
        logic       nosync;
        logic       crc_ok;
        logic       fifo_full;
        logic [7:0] addr;
        logic [5:0] len;
    } rtts_ack_t;

endpackage

/* core/rtts_sequencer.sv */
// Purpose: transmit task sequencer of the link_engine
// Assumes: tx fifo byte stream with valid/ready, receiver reports ack
// Notes:   wishbone classic slave, ack one cycle after strobe
`timescale 1ns/1ns
`default_nettype none
module rtts_sequencer
    import rtts_pkg::*;
(
    // clock and reset
    input  wire logic          i_clk_sys,
    input  wire logic          i_reset,
    // wishbone slave
    input  wire logic          i_wb_cyc,
    input  wire logic          i_wb_stb,
    input  wire logic          i_wb_we,
    input  wire logic [7:0]    i_wb_adr,
    input  wire logic [3:0]    i_wb_sel,
    input  wire logic [31:0]   i_wb_dat,
    output logic      [31:0]   o_wb_dat,
    output logic               o_wb_ack,
    // tx fifo read side
    input  wire logic          i_txf_avail,
    input  wire logic [7:0]    i_txf_data,
    output logic               o_txf_read,
    output rtts_fifo_cmd_t     o_fifo_cmd,
    // radio modulator byte stream
    output logic [7:0]         o_mod_data,
    output logic               o_mod_valid,
    output logic [7:0]         o_mod_chan,
    output logic               o_mod_on,
    output logic               o_rx_on,
    // acknowledgment from receiver
    input  wire rtts_ack_t     i_ack,
    // status
    output logic               o_busy
);

    // ------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000, ST_CHECK = 4'b0001, ST_LEN   = 4'b0010,
        ST_CFG   = 4'b0011, ST_ADDR  = 4'b0100, ST_HDR   = 4'b0101,
        ST_PAY   = 4'b0110, ST_CRC   = 4'b0111, ST_POST  = 4'b1000,
        ST_LISTN = 4'b1001, ST_WAIT  = 4'b1010, ST_HDR2  = 4'b1011
    } rtts_state_t;

    rtts_state_t  state_q;
    logic [31:0]  conf_q;
    logic [7:0]   chan_q, timeout_q, rtdelay_q;
    logic [7:0]   entry_addr_q [4];
    logic [1:0]   seq_q [4];
    logic [7:0]   len_q, cnt_q, cfg_q;
    logic [1:0]   idx_q;
    logic [3:0]   rt_done_q;
    logic [15:0]  timer_q;
    logic [2:0]   cause_q;
    logic         crc_pass_q;
    logic [7:0]   ev_q, ev_set;
    logic [15:0]  n_tx_q, n_done_q, received_ok_counter_q, n_rxign_q, n_rxbad_q;
    logic         noack_q, start_q;

    // current config fields
    wire [1:0] mode   = conf_q[CF_MODE+:2];
    wire [1:0] asrc   = conf_q[CF_ADSRC+:2];
    wire       auto_m = mode[1];
    wire [1:0] crclen = conf_q[CF_CRCLEN+:2];
    wire [3:0] rtlim  = conf_q[CF_RTLIM+:4];
    wire [5:0] rxlim  = conf_q[CF_RXLIM+:6];
    wire       cfgb   = conf_q[CF_CFGBYTE];

    // cycles for a count of 62.5 ns units, rounded down, at least one
    function automatic logic [15:0] units_to_cycles(input logic [7:0] u);
        logic [31:0] c;
        c = (32'(u) * UNIT_PS) / CLK_PS;
        units_to_cycles = (c == 32'h0) ? 16'h1 : c[15:0];
    endfunction

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    wire wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire wb_wr  = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack; // at ack edge

    // byte-lane merge of write data into a register
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            lane_merge[b*8+:8] = sel[b] ? nw[b*8+:8] : old[b*8+:8];
        end
    endfunction

    // ack and read data, one cycle after request
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_req;
            if (wb_req && !i_wb_we) begin
                case (i_wb_adr)
                    ADDR_CTRL:   o_wb_dat <= {31'h0, o_busy};
                    ADDR_CHAN:   o_wb_dat <= {24'h0, chan_q};
                    ADDR_CONF:   o_wb_dat <= conf_q;
                    ADDR_TIME:   o_wb_dat <= {16'h0, rtdelay_q, timeout_q};
                    ADDR_ENTRY:  o_wb_dat <= {entry_addr_q[3],
                                    entry_addr_q[2], entry_addr_q[1],
                                    entry_addr_q[0]};
                    ADDR_STATUS: o_wb_dat <= {16'h0, crc_pass_q, 5'h0,
                                    seq_q[idx_q], rt_done_q, cause_q,
                                    state_q == ST_IDLE ? 1'b0 : 1'b1};
                    ADDR_CNT_TX: o_wb_dat <= {n_done_q, n_tx_q};
                    ADDR_CNT_RX: o_wb_dat <= {n_rxbad_q, n_rxign_q[7:0],
                                    received_ok_counter_q[7:0]};
                    ADDR_EVENTS: o_wb_dat <= {24'h0, ev_q};
                    default:     o_wb_dat <= 32'h0;
                endcase
            end
        end
    end

    // configuration writes
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            conf_q    <= 32'h0;
            chan_q    <= 8'h0;
            timeout_q <= 8'h0;
            rtdelay_q <= 8'h0;
            for (int i = 0; i < 4; i++) entry_addr_q[i] <= 8'h0;
        end else if (wb_wr) begin
            case (i_wb_adr)
                ADDR_CHAN: if (i_wb_sel[0]) chan_q <= i_wb_dat[7:0];
                ADDR_CONF: conf_q <= lane_merge(conf_q, i_wb_dat, i_wb_sel);
                ADDR_TIME: begin
                    if (i_wb_sel[0]) timeout_q <= i_wb_dat[7:0];
                    if (i_wb_sel[1]) rtdelay_q <= i_wb_dat[15:8];
                end
                ADDR_ENTRY: begin
                    for (int i = 0; i < 4; i++)
                        if (i_wb_sel[i]) entry_addr_q[i] <= i_wb_dat[i*8+:8];
                end
                default: ;
            endcase
        end
    end

    // start pulse; sticky events, set wins over write-one-to-clear
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            start_q <= 1'b0;
            ev_q    <= 8'h0;
        end else begin
            start_q <= wb_wr && i_wb_adr == ADDR_CTRL && i_wb_sel[0] &&
                       i_wb_dat[CTRL_START];
            if (wb_wr && i_wb_adr == ADDR_EVENTS && i_wb_sel[0])
                ev_q <= (ev_q & ~i_wb_dat[7:0]) | ev_set;
            else
                ev_q <= ev_q | ev_set;
        end
    end

    // ------------------------------------------------------------------
    // transmit sequencer
    // ------------------------------------------------------------------
    wire ack_expect = conf_q[CF_AA] && !noack_q;
    wire ack_good   = i_ack.valid && i_ack.crc_ok && !i_ack.fifo_full;
    wire addr_bad   = conf_q[CF_ADLEN] &&
                      i_ack.addr != entry_addr_q[idx_q];
    wire len_bad    = conf_q[CF_VARIABLE_LENGTH_FLAG] && i_ack.len > rxlim;
    wire [1:0] hdr_seq = conf_q[CF_FIXSEQ] ? cfg_q[7:6]
                                           : seq_q[idx_q];

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_q    <= ST_IDLE;
            o_txf_read <= 1'b0;
            o_fifo_cmd <= '0;
            o_mod_data <= 8'h0;
            o_mod_valid <= 1'b0;
            o_mod_chan <= 8'h0;
            o_mod_on   <= 1'b0;
            o_rx_on    <= 1'b0;
            o_busy     <= 1'b0;
            len_q <= 8'h0; cnt_q <= 8'h0; cfg_q <= 8'h0; idx_q <= 2'h0;
            rt_done_q <= 4'h0; timer_q <= 16'h0; cause_q <= CAUSE_NONE;
            crc_pass_q <= 1'b0; noack_q <= 1'b0; ev_set <= 8'h0;
            n_tx_q <= 16'h0; n_done_q <= 16'h0; received_ok_counter_q <= 16'h0;
            n_rxign_q <= 16'h0; n_rxbad_q <= 16'h0;
            for (int i = 0; i < 4; i++) seq_q[i] <= 2'h0;
        end else begin
            o_txf_read  <= 1'b0;
            o_fifo_cmd  <= '0;
            o_mod_valid <= 1'b0;
            ev_set      <= 8'h0;
            o_busy      <= state_q != ST_IDLE;
            case (state_q)
                ST_IDLE: if (start_q) begin
                    o_mod_chan <= chan_q;
                    rt_done_q  <= 4'h0;
                    cause_q    <= CAUSE_NONE;
                    state_q    <= ST_CHECK;
                end
                ST_CHECK: begin
                    if (!i_txf_avail) begin
                        cause_q <= CAUSE_TXF;
                        ev_set[EV_ERR]   <= 1'b1;
                        ev_set[EV_ABORT] <= 1'b1;
                        ev_set[EV_DONE]  <= 1'b1;
                        o_mod_on <= 1'b0;
                        state_q  <= ST_IDLE;
                    end else begin
                        o_mod_on   <= 1'b1;
                        len_q      <= i_txf_data;
                        o_txf_read <= 1'b1;
                        cfg_q <= 8'h0; noack_q <= 1'b0; idx_q <= 2'h0;
                        cnt_q <= 8'h1;
                        timer_q <= 16'h0;  // counts crc bytes later
                        state_q <= cfgb ? ST_CFG : ST_ADDR;
                    end
                end
                ST_CFG: if (!o_txf_read) begin
                    // config byte is the first byte counted in length
                    cfg_q      <= i_txf_data;
                    o_txf_read <= 1'b1;
                    cnt_q      <= cnt_q + 8'h1;
                    noack_q    <= auto_m && i_txf_data[5];
                    if (asrc == ASRC_INDEX)
                        idx_q <= i_txf_data[1:0];
                    state_q <= ST_ADDR;
                end
                ST_ADDR: begin
                    // primary sync word sent by modem regardless
                    if (conf_q[CF_ADDRCFG] && asrc != ASRC_FIFO) begin
                        o_mod_data  <= entry_addr_q[idx_q];
                        o_mod_valid <= 1'b1;
                    end
                    state_q <= ST_HDR;
                end
                ST_HDR: begin
                    if (mode == MODE_BASIC_LEN) begin
                        o_mod_data  <= len_q - (cnt_q - 8'h1);
                        o_mod_valid <= 1'b1;
                    end else if (auto_m) begin
                        o_mod_data  <= conf_q[CF_FIXLEN] ?
                            (conf_q[CF_HDR10] ? {1'b0, FIXLEN_10BIT}
                                              : {1'b0, FIXLEN_9BIT})
                            : len_q - (cnt_q - 8'h1);
                        o_mod_valid <= 1'b1;
                    end
                    if (auto_m)
                        state_q <= ST_HDR2;
                    else
                        state_q <= (cnt_q > len_q) ? ST_CRC : ST_PAY;
                end
                ST_HDR2: begin
                    // second header byte: sequence and no-ack bits
                    o_mod_data  <= {5'h0, hdr_seq, noack_q};
                    o_mod_valid <= 1'b1;
                    state_q <= (cnt_q > len_q) ? ST_CRC : ST_PAY;
                end
                ST_PAY: if (!o_txf_read) begin
                    // one byte per two cycles: the read pop must land first
                    // bytes read blindly; underflow is the fifo's
                    o_mod_data  <= i_txf_data;
                    o_mod_valid <= 1'b1;
                    o_txf_read  <= 1'b1;
                    cnt_q       <= cnt_q + 8'h1;
                    if (cnt_q == len_q) state_q <= ST_CRC;
                end
                ST_CRC: begin
                    // modem appends crc_byte_count bytes after payload
                    if (timer_q[1:0] < crclen) begin
                        o_mod_data  <= 8'h0;
                        o_mod_valid <= 1'b1;
                        timer_q     <= timer_q + 16'h1;
                    end else begin
                        ev_set[EV_TRANSMIT_DONE_IRQ] <= !auto_m;
                        n_tx_q <= n_tx_q + 16'h1;
                        state_q <= ST_POST;
                    end
                end
                ST_POST: begin
                    o_mod_on <= 1'b0;
                    if (!auto_m) begin
                        o_fifo_cmd.dealloc <= !conf_q[CF_REUSE];
                        cause_q <= CAUSE_OK;
                        ev_set[EV_DONE] <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (!ack_expect) begin
                        o_fifo_cmd.dealloc <= !conf_q[CF_REUSE];
                        n_done_q <= n_done_q + 16'h1;
                        ev_set[EV_TRANSMIT_DONE_IRQ] <= 1'b1;
                        ev_set[EV_DONE]   <= 1'b1;
                        if (!conf_q[CF_FIXSEQ])
                            seq_q[idx_q] <= seq_q[idx_q] + 2'h1;
                        cause_q <= CAUSE_OK;
                        state_q <= ST_IDLE;
                    end else begin
                        o_rx_on <= 1'b1;
                        timer_q <= units_to_cycles(timeout_q);
                        state_q <= ST_LISTN;
                    end
                end
                ST_LISTN: begin
                    timer_q <= timer_q - 16'h1;
                    if (i_ack.valid && (addr_bad || len_bad)) begin
                        // stop reception, keep searching for sync
                    end else if (i_ack.valid || timer_q == 16'h0 ||
                                 i_ack.nosync) begin
                        o_rx_on <= 1'b0;
                        if (i_ack.valid) begin
                            crc_pass_q <= i_ack.crc_ok;
                            o_fifo_cmd.discard <= !i_ack.crc_ok &&
                                                  conf_q[CF_AFLUSH];
                            if (!i_ack.crc_ok) begin
                                n_rxbad_q <= n_rxbad_q + 16'h1;
                                ev_set[EV_RXBAD] <= 1'b1;
                            end else if (i_ack.len != 6'h0) begin
                                received_ok_counter_q <= received_ok_counter_q + 16'h1;
                                ev_set[EV_RECEIVE_OK_IRQ] <= 1'b1;
                            end else begin
                                n_rxign_q <= n_rxign_q + 16'h1;
                                ev_set[EV_RXEMP] <= 1'b1;
                            end
                        end
                        if (ack_good) begin
                            o_fifo_cmd.dealloc <= !conf_q[CF_REUSE];
                            n_done_q <= n_done_q + 16'h1;
                            ev_set[EV_TRANSMIT_DONE_IRQ] <= 1'b1;
                            ev_set[EV_DONE]   <= 1'b1;
                            if (!conf_q[CF_FIXSEQ])
                                seq_q[idx_q] <= seq_q[idx_q] + 2'h1;
                            cause_q <= CAUSE_OK;
                            state_q <= ST_IDLE;
                        end else if (i_ack.valid && i_ack.fifo_full) begin
                            o_fifo_cmd.retry <= 1'b1;
                            ev_set[EV_RXFULL] <= 1'b1;
                            ev_set[EV_DONE]   <= 1'b1;
                            cause_q <= CAUSE_RXF;
                            state_q <= ST_IDLE;
                        end else begin
                            o_fifo_cmd.retry <= 1'b1;
                            if (rt_done_q == rtlim) begin
                                cause_q <= CAUSE_MAXRT;
                                ev_set[EV_DONE] <= 1'b1;
                                state_q <= ST_IDLE;
                            end else begin
                                rt_done_q <= rt_done_q + 4'h1;
                                timer_q <= units_to_cycles(rtdelay_q);
                                state_q <= ST_WAIT;
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    timer_q <= timer_q - 16'h1;
                    if (timer_q == 16'h0) state_q <= ST_CHECK;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

/* sim/rtts_seq_sva.sv */
// Purpose: port assertions for the transmit sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by the bind at the foot
`timescale 1ns/1ns
`default_nettype none
module rtts_seq_sva
    import rtts_pkg::*;
(
    input wire logic           i_clk_sys, i_reset, i_wb_cyc, i_wb_stb,
    input wire logic           o_wb_ack, o_busy, o_rx_on, o_mod_on,
    input wire logic           o_txf_read,
    input wire logic [7:0]     o_mod_chan,
    input wire rtts_fifo_cmd_t o_fifo_cmd
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // bus answer timing
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
    a_ack_answer: assert property
        (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
    a_ack_cause: assert property ($rose(o_wb_ack) |-> $past(i_wb_stb))
        else $error("stray ack");
    // task outputs
    a_cmd_excl: assert property
        (!(o_fifo_cmd.dealloc && o_fifo_cmd.retry)) else $error("two cmds");
    a_chan_held: assert property
        (o_busy && $past(o_busy, 2) |-> $stable(o_mod_chan)) else $error("chan");
    a_radio_excl: assert property (!(o_mod_on && o_rx_on))
        else $error("tx and rx on");
    a_rx_task: assert property (o_rx_on |-> o_busy) else $error("rx idle");
    a_read_task: assert property (o_txf_read |-> o_busy)
        else $error("read idle");
endmodule
bind rtts_sequencer rtts_seq_sva chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
    .o_busy(o_busy), .o_rx_on(o_rx_on), .o_mod_on(o_mod_on),
    .o_txf_read(o_txf_read), .o_mod_chan(o_mod_chan), .o_fifo_cmd(o_fifo_cmd));
`default_nettype wire

/* sim/rtts_peer.sv */
// Purpose: peer receiver answering acknowledgment searches
// Assumes: one search per rise of the receiver enable
// Notes:   fields scramble while no result is shown
`timescale 1ns/1ns
`default_nettype none
module rtts_peer
    import rtts_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rx_on,
    input  wire logic i_answer,
    output rtts_ack_t o_ack = '0
);
    logic [3:0] cnt_q = 4'h0;
    // good ack with three bytes, or give up, six cycles
    always @(posedge i_clk_sys) begin
        cnt_q <= (cnt_q != 4'h0) ? cnt_q + 4'h1 : {3'h0, i_rx_on};
        o_ack <= (cnt_q == 4'h6) ? {i_answer, !i_answer, 16'h8003}
                                 : {4'h0, 14'($random)};
    end
endmodule
`default_nettype wire

/* sim/radio_transmit_task_sequencer_tb.sv */
// Purpose: self-checking bench for the transmit sequencer
// Assumes: fifo model here, peer receiver beside
// Notes:   reads checked by a monitor against a queue
`timescale 1ns/1ns
`default_nettype none
module radio_transmit_task_sequencer_tb
    import rtts_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic avail = 1'b0, ans = 1'b0, ack, rd_, mv, mon, rxon, busy;
    logic [7:0] adr = 8'h0, txd = 8'h0, chan, mch, md, fq[$], fb[$], xq[$];
    logic [31:0] wd = 32'h0, rdat, eq[$], mq[$];
    rtts_fifo_cmd_t cmd;
    rtts_ack_t pk;
    int num_errors = 0, cmp_count = 0, seed = 32'hca215ea0, nret, ndeal;
    rtts_sequencer uut (.i_clk_sys(clk), .i_reset(rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
        .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .i_txf_avail(avail),
        .i_txf_data(txd), .o_txf_read(rd_), .o_fifo_cmd(cmd), .o_mod_data(md),
        .o_mod_valid(mv), .o_mod_chan(mch), .o_mod_on(mon), .o_rx_on(rxon),
        .i_ack(pk), .o_busy(busy));
    rtts_peer peer (.i_clk_sys(clk), .i_rx_on(rxon), .i_answer(ans), .o_ack(pk));
    initial forever #10 clk = ~clk;
    initial begin
        #1500000;
        num_errors++;
        final_report();
    end
    task automatic final_report();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, m, input string s);
        cmp_count++;
        if (((g ^ e) & m) !== 32'h0) begin
            num_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    // read results against the oldest note
    always @(posedge clk) if (ack === 1'b1 && !we) chk(rdat, eq.pop_front(), mq.pop_front(), "rd");
    // modulator bytes against the oldest expected byte, sender on
    always @(posedge clk) if (mv === 1'b1)
        chk({23'h0, mon, md}, {24'h1, xq.pop_front()}, 32'h1ff, "md");
    // fifo model: pop on read, rewind on retry, scramble when empty
    always @(posedge clk) begin
        if (rd_ === 1'b1) void'(fq.pop_front());
        if (cmd.retry === 1'b1) fq = fb;
        nret += int'(cmd.retry === 1'b1);
        ndeal += int'(cmd.dealloc === 1'b1);
        avail <= fq.size() > 0;
        txd <= (fq.size() > 0) ? fq[0] : 8'($random(seed));
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
        if (ack !== 1'b1) num_errors++;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        eq.push_back(e);
        mq.push_back(m);
        wb(1'b0, a, 32'h0);
    endtask
    // host replaces the queue between tasks, length kept small
    task automatic load(input int n);
        @(negedge clk);
        fb = {8'(n)};
        repeat (n) fb.push_back(8'($random(seed)));
        fq = fb;
        {nret, ndeal} = 64'h0;
    endtask
    task automatic run(input logic [31:0] conf);
        int n = 0;
        wb(1'b1, ADDR_EVENTS, 32'hff);
        wb(1'b1, ADDR_CONF, conf);
        wb(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        while (busy !== 1'b0 && ++n < 20000) @(posedge clk);
        if (busy !== 1'b0) num_errors++;
    endtask
    // frame as sent k times: length, auto header byte, payload as stored
    task automatic frame(input int k, input logic a);
        repeat (k) foreach (fb[i]) begin
            xq.push_back(fb[i]);
            if (a && i == 0) xq.push_back(8'h0);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_STATUS, 32'h0, 32'hffff);
        rd(8'h24, 32'h0, 32'hffffffff);
        chan = 8'($random(seed));
        wb(1'b1, ADDR_CHAN, {24'h0, chan});
        wb(1'b1, ADDR_TIME, 32'h0410);
        wb(1'b1, ADDR_ENTRY, 32'h0);
        run(32'h1);
        rd(ADDR_STATUS, 32'h4, 32'he);
        rd(ADDR_EVENTS, 32'he0, 32'hff);
        $display("empty fifo test done");
        load(1 + ($random(seed) & 7));
        frame(1, 1'b0);
        run(32'h1);
        chk({24'h0, mch}, {24'h0, chan}, 32'hff, "chan");
        chk(fq.size(), 0, 32'hff, "fifo left");
        chk(ndeal, 1, 32'hff, "dealloc");
        chk(xq.size(), 0, 32'hff, "bytes left");
        rd(ADDR_STATUS, 32'h2, 32'he);
        rd(ADDR_EVENTS, 32'h81, 32'hff);
        $display("basic test done");
        load(1 + ($random(seed) & 7));
        frame(2, 1'b1);
        run(32'h10082);
        chk(nret, 2, 32'hff, "retry");
        chk(xq.size(), 0, 32'hff, "bytes left");
        rd(ADDR_STATUS, 32'h16, 32'h3fe);
        rd(ADDR_EVENTS, 32'h80, 32'h81);
        $display("no ack test done");
        ans <= 1'b1;
        load(1 + ($random(seed) & 7));
        frame(1, 1'b1);
        run(32'h10082);
        chk(ndeal, 1, 32'hff, "dealloc");
        chk(xq.size(), 0, 32'hff, "bytes left");
        rd(ADDR_STATUS, 32'h8102, 32'h83fe);
        rd(ADDR_EVENTS, 32'h83, 32'h8f);
        $display("ack test done");
        final_report();
    end
endmodule
`default_nettype wire
